// ==== rtl/csocr_pkg.sv ====
// Constants for the output-stage configuration register bank.
// Assumes an 8-bit offset bus with one-cycle read latency.
// Summary of operation
// - Override bit selects programmed trail value
// - Justify bit moves RAW to high bits
// - Port A lanes reset 3Fh, writable
// - Port B lanes reset zero, writable
// - Gpio3 bit routes pass to pin 3
// - Gpio0 bit routes pass, resets set
// - Status bit zero shows live pass
// - Two-bit field picks virtual channel id
// - Fifth identification byte read-only at F4h
// - Sixth identification byte read-only at F5h
package csocr_pkg;
    // Register offsets
    localparam logic [7:0] OFF_TRAIL = 8'h02;
    localparam logic [7:0] OFF_JUSTIFY = 8'h09;
    localparam logic [7:0] OFF_PORT_A = 8'h13;
    localparam logic [7:0] OFF_PORT_B = 8'h14;
    localparam logic [7:0] OFF_PASS = 8'h16;
    localparam logic [7:0] OFF_VC = 8'h2E;
    localparam logic [7:0] OFF_ID_FIFTH = 8'hF4;
    localparam logic [7:0] OFF_ID_SIXTH = 8'hF5;
    // Reset values
    localparam logic [7:0] RST_TRAIL = 8'h00;
    localparam logic [7:0] RST_JUSTIFY = 8'h00;
    localparam logic [7:0] RST_PORT_A = 8'h3F;
    localparam logic [7:0] RST_PORT_B = 8'h00;
    localparam logic [7:0] RST_PASS = 8'h02;
    localparam logic [7:0] RST_VC = 8'h00;
    // Identification bytes, values arbitrary
    localparam logic [7:0] ID_FIFTH = 8'hA5;
    localparam logic [7:0] ID_SIXTH = 8'h5A;
    // Field positions
    localparam int TRAIL_OV_BIT = 7;
    localparam int JUSTIFY_BIT = 4;
    localparam int PASS_GP3_BIT = 2;
    localparam int PASS_GP0_BIT = 1;
    localparam int PASS_STAT_BIT = 0;
    localparam int VC_LSB = 6;
    localparam logic [5:0] LANES_ON = 6'h3F;
    localparam logic [5:0] LANES_OFF = 6'h00;
    // Pixel bus widths
    localparam int RAW_W = 12;
    localparam int RGB_W = 24;
endpackage : csocr_pkg

// ==== rtl/csocr_reg8.sv ====
// One 8-bit writable register with reset value.
// Assumes a write enable from the same clock domain.
`timescale 1ns/100ps
module csocr_reg8 #(
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Write side
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    // Stored value
    output logic [7:0] q
);
    // Holds last write, else reset value
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            q <= RESET_VAL;
        end else if (wr_en) begin
            q <= wr_data;
        end
    end
endmodule : csocr_reg8

// ==== rtl/csocr_sync.sv ====
// Two-flop synchroniser for a single level.
// Assumes the input is asynchronous to core_clk.
`timescale 1ns/100ps
module csocr_sync (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Level in and out
    input wire logic async_in,
    output logic sync_out
);
    logic meta_reg;
    // First stage feeds only the second
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : csocr_sync

// ==== rtl/csocr_regs.sv ====
// Output-stage configuration registers and the logic they steer.
// Assumes pass_in and auto_trail come from outside the clock domain.
`timescale 1ns/100ps
module csocr_regs (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Link status and timing
    input wire logic pass_in,
    input wire logic [3:0] auto_trail,
    // Pixel path
    input wire logic [11:0] raw_pixel,
    output logic [23:0] rgb_bus,
    // Output port controls
    output logic [3:0] trail_value,
    output logic [5:0] port_a_lane_enable,
    output logic [5:0] port_b_lane_enable,
    output logic port_a_reg_control,
    output logic port_b_reg_control,
    output logic [1:0] virtual_channel_field,
    // General-purpose pins
    output logic gpio0_out,
    output logic gpio0_oe,
    output logic gpio3_out,
    output logic gpio3_oe
);
    logic [7:0] trail_q;
    logic [7:0] justify_q;
    logic [7:0] port_a_q;
    logic [7:0] port_b_q;
    logic [7:0] pass_q;
    logic [7:0] vc_q;
    logic pass_sync;
    logic [3:0] auto_meta_reg;
    logic [3:0] auto_sync_reg;
    logic [3:0] auto_prev_reg;
    logic [3:0] auto_stable_reg;

    // Write decode per register
    wire logic wr_trail = reg_wr && (reg_addr == csocr_pkg::OFF_TRAIL);
    wire logic wr_justify = reg_wr && (reg_addr == csocr_pkg::OFF_JUSTIFY);
    wire logic wr_port_a = reg_wr && (reg_addr == csocr_pkg::OFF_PORT_A);
    wire logic wr_port_b = reg_wr && (reg_addr == csocr_pkg::OFF_PORT_B);
    wire logic wr_pass = reg_wr && (reg_addr == csocr_pkg::OFF_PASS);
    wire logic wr_vc = reg_wr && (reg_addr == csocr_pkg::OFF_VC);

    // Any mapped write, and every stored byte, for the stray-write check
    wire logic wr_mapped =
        wr_trail || wr_justify || wr_port_a || wr_port_b || wr_pass || wr_vc;
    wire logic [47:0] stored_all = {trail_q, justify_q, port_a_q, port_b_q, pass_q, vc_q};

    // Stored registers; unlisted offsets ignore writes
    csocr_reg8 #(.RESET_VAL(csocr_pkg::RST_TRAIL)) u_trail (
        .core_clk(core_clk), .rst(rst), .wr_en(wr_trail), .wr_data(reg_wdata), .q(trail_q)
    );
    csocr_reg8 #(.RESET_VAL(csocr_pkg::RST_JUSTIFY)) u_justify (
        .core_clk(core_clk), .rst(rst), .wr_en(wr_justify), .wr_data(reg_wdata),
        .q(justify_q)
    );
    csocr_reg8 #(.RESET_VAL(csocr_pkg::RST_PORT_A)) u_port_a (
        .core_clk(core_clk), .rst(rst), .wr_en(wr_port_a), .wr_data(reg_wdata),
        .q(port_a_q)
    );
    csocr_reg8 #(.RESET_VAL(csocr_pkg::RST_PORT_B)) u_port_b (
        .core_clk(core_clk), .rst(rst), .wr_en(wr_port_b), .wr_data(reg_wdata),
        .q(port_b_q)
    );
    csocr_reg8 #(.RESET_VAL(csocr_pkg::RST_PASS)) u_pass (
        .core_clk(core_clk), .rst(rst), .wr_en(wr_pass), .wr_data(reg_wdata), .q(pass_q)
    );
    csocr_reg8 #(.RESET_VAL(csocr_pkg::RST_VC)) u_vc (
        .core_clk(core_clk), .rst(rst), .wr_en(wr_vc), .wr_data(reg_wdata), .q(vc_q)
    );

    // Pass signal comes from the link logic, asynchronous here
    csocr_sync u_pass_sync (
        .core_clk(core_clk), .rst(rst), .async_in(pass_in), .sync_out(pass_sync)
    );

    // Automatic trail value is quasi-static, but its bits may land on different edges;
    // a new word is only taken once two synced samples agree
    wire logic auto_steady = (auto_sync_reg == auto_prev_reg);
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            auto_meta_reg <= 4'h0;
            auto_sync_reg <= 4'h0;
            auto_prev_reg <= 4'h0;
            auto_stable_reg <= 4'h0;
        end else begin
            auto_meta_reg <= auto_trail;
            auto_sync_reg <= auto_meta_reg;
            auto_prev_reg <= auto_sync_reg;
            if (auto_steady) begin
                auto_stable_reg <= auto_sync_reg;
            end
        end
    end

    // Read mux; status bit is live, not stored
    wire logic [7:0] pass_view = {pass_q[7:1], pass_sync};
    wire logic [7:0] rd_mux =
        (reg_addr == csocr_pkg::OFF_TRAIL) ? trail_q :
        (reg_addr == csocr_pkg::OFF_JUSTIFY) ? justify_q :
        (reg_addr == csocr_pkg::OFF_PORT_A) ? port_a_q :
        (reg_addr == csocr_pkg::OFF_PORT_B) ? port_b_q :
        (reg_addr == csocr_pkg::OFF_PASS) ? pass_view :
        (reg_addr == csocr_pkg::OFF_VC) ? vc_q :
        (reg_addr == csocr_pkg::OFF_ID_FIFTH) ? csocr_pkg::ID_FIFTH :
        (reg_addr == csocr_pkg::OFF_ID_SIXTH) ? csocr_pkg::ID_SIXTH :
        8'h00; // Unmapped offsets read zero

    // Offsets that answer a read; all others read zero
    wire logic rd_mapped =
        (reg_addr == csocr_pkg::OFF_TRAIL) || (reg_addr == csocr_pkg::OFF_JUSTIFY) ||
        (reg_addr == csocr_pkg::OFF_PORT_A) || (reg_addr == csocr_pkg::OFF_PORT_B) ||
        (reg_addr == csocr_pkg::OFF_PASS) || (reg_addr == csocr_pkg::OFF_VC) ||
        (reg_addr == csocr_pkg::OFF_ID_FIFTH) || (reg_addr == csocr_pkg::OFF_ID_SIXTH);

    // Trail selection between automatic and programmed value
    wire logic trail_ov = trail_q[csocr_pkg::TRAIL_OV_BIT];
    wire logic [3:0] trail_sel = trail_ov ? trail_q[3:0] : auto_stable_reg;

    // RAW placement on the RGB bus
    wire logic justify_hi = justify_q[csocr_pkg::JUSTIFY_BIT];
    wire logic [23:0] rgb_sel = justify_hi ?
        {raw_pixel, 12'h000} : {12'h000, raw_pixel};

    // Pass routing to the two pins
    wire logic route_gp3 = pass_q[csocr_pkg::PASS_GP3_BIT];
    wire logic route_gp0 = pass_q[csocr_pkg::PASS_GP0_BIT];

    // Outputs registered; one cycle behind the configuration
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            trail_value <= 4'h0;
            rgb_bus <= 24'h000000;
            port_a_lane_enable <= csocr_pkg::RST_PORT_A[5:0];
            port_b_lane_enable <= csocr_pkg::RST_PORT_B[5:0];
            port_a_reg_control <= 1'b0;
            port_b_reg_control <= 1'b0;
            virtual_channel_field <= 2'h0;
            gpio0_out <= 1'b0;
            gpio0_oe <= csocr_pkg::RST_PASS[csocr_pkg::PASS_GP0_BIT];
            gpio3_out <= 1'b0;
            gpio3_oe <= 1'b0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
            trail_value <= trail_sel;
            rgb_bus <= rgb_sel;
            port_a_lane_enable <= port_a_q[5:0];
            port_b_lane_enable <= port_b_q[5:0];
            port_a_reg_control <= port_a_q[7];
            port_b_reg_control <= port_b_q[7];
            virtual_channel_field <= vc_q[csocr_pkg::VC_LSB +: 2];
            gpio0_out <= route_gp0 & pass_sync;
            gpio0_oe <= route_gp0;
            gpio3_out <= route_gp3 & pass_sync;
            gpio3_oe <= route_gp3;
        end
    end

    // Checks beside the logic
    chk_trail_override: assert property (@(posedge core_clk) disable iff (rst)
        trail_ov |=> trail_value == $past(trail_q[3:0]))
        else $error("trail value not taken from register");
    chk_trail_auto: assert property (@(posedge core_clk) disable iff (rst)
        !trail_ov |=> trail_value == $past(auto_stable_reg))
        else $error("trail value not automatic");
    chk_raw_justify: assert property (@(posedge core_clk) disable iff (rst)
        justify_hi |=> rgb_bus[23:12] == $past(raw_pixel) && rgb_bus[11:0] == 12'h000)
        else $error("raw data not on high bits");
    chk_port_a_write: assert property (@(posedge core_clk) disable iff (rst)
        wr_port_a |-> ##2 port_a_lane_enable == $past(reg_wdata[5:0], 2))
        else $error("port a lanes not updated");
    chk_port_b_write: assert property (@(posedge core_clk) disable iff (rst)
        wr_port_b |-> ##2 port_b_lane_enable == $past(reg_wdata[5:0], 2))
        else $error("port b lanes not updated");
    chk_gpio3_route: assert property (@(posedge core_clk) disable iff (rst)
        !route_gp3 |=> !gpio3_oe && !gpio3_out)
        else $error("gpio3 driven without routing");
    chk_gpio0_route: assert property (@(posedge core_clk) disable iff (rst)
        route_gp0 |=> gpio0_oe && gpio0_out == $past(pass_sync))
        else $error("gpio0 does not follow pass");
    chk_pass_status: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr == csocr_pkg::OFF_PASS |=> reg_rdata[0] == $past(pass_sync))
        else $error("pass status not live");
    chk_vc_write: assert property (@(posedge core_clk) disable iff (rst)
        wr_vc |-> ##2 virtual_channel_field == $past(reg_wdata[7:6], 2))
        else $error("virtual channel not updated");
    chk_id_fifth: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr == csocr_pkg::OFF_ID_FIFTH |=> reg_rdata == csocr_pkg::ID_FIFTH)
        else $error("fifth id byte wrong");
    chk_id_sixth: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr == csocr_pkg::OFF_ID_SIXTH |=> reg_rdata == csocr_pkg::ID_SIXTH)
        else $error("sixth id byte wrong");
    chk_readback_vc: assert property (@(posedge core_clk) disable iff (rst)
        wr_vc ##1 (reg_rd && reg_addr == csocr_pkg::OFF_VC && !reg_wr) |=>
        reg_rdata == $past(reg_wdata, 2))
        else $error("written value not read back");

    // Each mapped write lands in its own register only
    chk_trail_store: assert property (@(posedge core_clk) disable iff (rst)
        wr_trail |=> trail_q == $past(reg_wdata))
        else $error("trail register not written");
    chk_justify_store: assert property (@(posedge core_clk) disable iff (rst)
        wr_justify |=> justify_q == $past(reg_wdata))
        else $error("justify register not written");
    chk_port_a_store: assert property (@(posedge core_clk) disable iff (rst)
        wr_port_a |=> port_a_q == $past(reg_wdata))
        else $error("port a register not written");
    chk_port_b_store: assert property (@(posedge core_clk) disable iff (rst)
        wr_port_b |=> port_b_q == $past(reg_wdata))
        else $error("port b register not written");
    chk_pass_store: assert property (@(posedge core_clk) disable iff (rst)
        wr_pass |=> pass_q == $past(reg_wdata))
        else $error("pass register not written");
    chk_vc_store: assert property (@(posedge core_clk) disable iff (rst)
        wr_vc |=> vc_q == $past(reg_wdata))
        else $error("channel register not written");
    chk_stray_write: assert property (@(posedge core_clk) disable iff (rst)
        !wr_mapped |=> stored_all == $past(stored_all))
        else $error("register changed without a write");

    // Read data per offset, and zero when idle or unmapped
    chk_trail_read: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr == csocr_pkg::OFF_TRAIL |=> reg_rdata == $past(trail_q))
        else $error("trail read wrong");
    chk_justify_read: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr == csocr_pkg::OFF_JUSTIFY |=> reg_rdata == $past(justify_q))
        else $error("justify read wrong");
    chk_port_a_read: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr == csocr_pkg::OFF_PORT_A |=> reg_rdata == $past(port_a_q))
        else $error("port a read wrong");
    chk_port_b_read: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr == csocr_pkg::OFF_PORT_B |=> reg_rdata == $past(port_b_q))
        else $error("port b read wrong");
    chk_vc_read: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr == csocr_pkg::OFF_VC |=> reg_rdata == $past(vc_q))
        else $error("channel read wrong");
    chk_pass_read: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr == csocr_pkg::OFF_PASS |=> reg_rdata[7:1] == $past(pass_q[7:1]))
        else $error("pass routing read wrong");
    chk_rdata_idle: assert property (@(posedge core_clk) disable iff (rst)
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero when idle");
    chk_unmapped_read: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && !rd_mapped |=> reg_rdata == 8'h00)
        else $error("unmapped offset not zero");

    // Automatic trail word only moves when steady
    chk_auto_take: assert property (@(posedge core_clk) disable iff (rst)
        auto_steady |=> auto_stable_reg == $past(auto_sync_reg))
        else $error("steady trail word not taken");
    chk_auto_hold: assert property (@(posedge core_clk) disable iff (rst)
        !auto_steady |=> auto_stable_reg == $past(auto_stable_reg))
        else $error("unsteady trail word taken");

    // Pixel placement when not justified high
    chk_raw_low: assert property (@(posedge core_clk) disable iff (rst)
        !justify_hi |=> rgb_bus == {12'h000, $past(raw_pixel)})
        else $error("raw data not on low bits");

    // Steered outputs and their steering bits hold while their register holds
    chk_port_a_steady: assert property (@(posedge core_clk) disable iff (rst)
        !wr_port_a |-> ##2 $stable(port_a_lane_enable))
        else $error("port a lanes moved without a write");
    chk_port_b_steady: assert property (@(posedge core_clk) disable iff (rst)
        !wr_port_b |-> ##2 $stable(port_b_lane_enable))
        else $error("port b lanes moved without a write");
    chk_vc_steady: assert property (@(posedge core_clk) disable iff (rst)
        !wr_vc |-> ##2 $stable(virtual_channel_field))
        else $error("channel moved without a write");
    chk_trail_ov_steady: assert property (@(posedge core_clk) disable iff (rst)
        !wr_trail |=> $stable(trail_ov))
        else $error("trail override moved without a write");
    chk_justify_steady: assert property (@(posedge core_clk) disable iff (rst)
        !wr_justify |=> $stable(justify_hi))
        else $error("justify moved without a write");
    chk_route_steady: assert property (@(posedge core_clk) disable iff (rst)
        !wr_pass |=> $stable(route_gp0) && $stable(route_gp3))
        else $error("pass routing moved without a write");

    // Register control bits follow their writes
    chk_port_a_ctl: assert property (@(posedge core_clk) disable iff (rst)
        wr_port_a |-> ##2 port_a_reg_control == $past(reg_wdata[7], 2))
        else $error("port a control not updated");
    chk_port_b_ctl: assert property (@(posedge core_clk) disable iff (rst)
        wr_port_b |-> ##2 port_b_reg_control == $past(reg_wdata[7], 2))
        else $error("port b control not updated");

    // Pins follow pass only while routed
    chk_gpio3_follow: assert property (@(posedge core_clk) disable iff (rst)
        route_gp3 |=> gpio3_oe && gpio3_out == $past(pass_sync))
        else $error("gpio3 does not follow pass");
    chk_gpio0_off: assert property (@(posedge core_clk) disable iff (rst)
        !route_gp0 |=> !gpio0_oe && !gpio0_out)
        else $error("gpio0 driven without routing");
    chk_pins_low_no_pass: assert property (@(posedge core_clk) disable iff (rst)
        !pass_sync |=> !gpio0_out && !gpio3_out)
        else $error("pin high without pass");
endmodule : csocr_regs

// ==== sim/test_csi2_output_config_regs.sv ====
// Self-checking bench for the output-stage configuration register bank.
// Assumes csocr_regs timing: read data one cycle after strobe, outputs two edges after a write.
`timescale 1ns/100ps
module test_csi2_output_config_regs;
    // Stimulus and observed signals
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic pass_in = 1'b0;
    logic [3:0] auto_trail = 4'h5;
    logic [11:0] raw_pixel = 12'hABC;
    logic [23:0] rgb_bus;
    logic [3:0] trail_value;
    logic [5:0] port_a_lane_enable;
    logic [5:0] port_b_lane_enable;
    logic port_a_reg_control;
    logic port_b_reg_control;
    logic [1:0] virtual_channel_field;
    logic gpio0_out, gpio0_oe, gpio3_out, gpio3_oe;
    int error_cnt = 0;
    int n_tests = 0;
    logic [7:0] offs [6] = '{csocr_pkg::OFF_TRAIL, csocr_pkg::OFF_JUSTIFY, csocr_pkg::OFF_PORT_A,
        csocr_pkg::OFF_PORT_B, csocr_pkg::OFF_PASS, csocr_pkg::OFF_VC};
    logic [7:0] pats [6] = '{8'hEF, 8'h7B, 8'hC0, 8'hBF, 8'hF9, 8'h95};

    // 50 MHz clock
    always #10 core_clk = ~core_clk;

    csocr_regs dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pass_in(pass_in),
        .auto_trail(auto_trail), .raw_pixel(raw_pixel), .rgb_bus(rgb_bus),
        .trail_value(trail_value), .port_a_lane_enable(port_a_lane_enable),
        .port_b_lane_enable(port_b_lane_enable), .port_a_reg_control(port_a_reg_control),
        .port_b_reg_control(port_b_reg_control), .virtual_channel_field(virtual_channel_field),
        .gpio0_out(gpio0_out), .gpio0_oe(gpio0_oe), .gpio3_out(gpio3_out), .gpio3_oe(gpio3_oe));

    // Four-state compare so an unknown never matches
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // Data is looked at only in the single cycle it stands
    task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        check($sformatf("read %h", a), {16'h0000, reg_rdata}, {16'h0000, exp});
    endtask : reg_read

    // Write strobe followed at once by a read of the same offset
    task automatic write_read(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        check($sformatf("write read %h", a), {16'h0000, reg_rdata}, {16'h0000, exp});
    endtask : write_read

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : settle

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    // Watchdog so a hang still ends in the verdict
    initial begin
        #400000;
        error_cnt++;
        end_of_test();
    end

    // Main sequence
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        reg_read(csocr_pkg::OFF_TRAIL, csocr_pkg::RST_TRAIL);
        reg_read(csocr_pkg::OFF_JUSTIFY, csocr_pkg::RST_JUSTIFY);
        reg_read(csocr_pkg::OFF_PORT_A, csocr_pkg::RST_PORT_A);
        reg_read(csocr_pkg::OFF_PORT_B, csocr_pkg::RST_PORT_B);
        reg_read(csocr_pkg::OFF_PASS, csocr_pkg::RST_PASS);
        reg_read(csocr_pkg::OFF_VC, csocr_pkg::RST_VC);
        reg_read(csocr_pkg::OFF_ID_FIFTH, csocr_pkg::ID_FIFTH);
        reg_read(csocr_pkg::OFF_ID_SIXTH, csocr_pkg::ID_SIXTH);
        check("lanes a", 24'(port_a_lane_enable), 24'(csocr_pkg::LANES_ON));
        check("lanes b", 24'(port_b_lane_enable), 24'(csocr_pkg::LANES_OFF));
        check("gpio oe", 24'({gpio3_oe, gpio0_oe}), 24'h000001);
        $display("test reset values done");
        // Readback; only listed offsets and the read-only bytes are ever written
        for (int i = 0; i < 6; i++) reg_write(offs[i], pats[i]);
        reg_write(csocr_pkg::OFF_ID_FIFTH, 8'h00);
        reg_write(csocr_pkg::OFF_ID_SIXTH, 8'hFF);
        for (int i = 0; i < 6; i++) reg_read(offs[i], (i == 4) ? 8'hF8 : pats[i]);
        reg_read(8'h03, 8'h00);
        reg_read(csocr_pkg::OFF_ID_FIFTH, csocr_pkg::ID_FIFTH);
        reg_read(csocr_pkg::OFF_ID_SIXTH, csocr_pkg::ID_SIXTH);
        settle(1);
        check("idle rdata", {16'h0000, reg_rdata}, 24'h000000);
        check("reg ctl", 24'({port_a_reg_control, port_b_reg_control}), 24'h000003);
        write_read(csocr_pkg::OFF_VC, 8'h7D, 8'h7D);
        $display("test readback done");
        // Trail source: automatic value unless overridden
        reg_write(csocr_pkg::OFF_TRAIL, 8'h0A);
        settle(4);
        check("trail auto", 24'(trail_value), 24'h000005);
        reg_write(csocr_pkg::OFF_TRAIL, 8'h8A);
        @(posedge core_clk);
        auto_trail <= 4'h3;
        settle(4);
        check("trail over", 24'(trail_value), 24'h00000A);
        reg_write(csocr_pkg::OFF_TRAIL, 8'h0A);
        settle(4);
        check("trail auto", 24'(trail_value), 24'h000003);
        $display("test trail done");
        // Pixel placement
        reg_write(csocr_pkg::OFF_JUSTIFY, 8'h00);
        settle(3);
        check("rgb low", rgb_bus, {12'h000, raw_pixel});
        reg_write(csocr_pkg::OFF_JUSTIFY, 8'h10);
        @(posedge core_clk);
        raw_pixel <= 12'h123;
        settle(3);
        check("rgb high", rgb_bus, {12'h123, 12'h000});
        $display("test justify done");
        // Lane enables both ways
        reg_write(csocr_pkg::OFF_PORT_A, 8'h00);
        reg_write(csocr_pkg::OFF_PORT_B, 8'h3F);
        settle(3);
        check("lanes", 24'({port_a_lane_enable, port_b_lane_enable}), 24'h00003F);
        reg_write(csocr_pkg::OFF_PORT_A, 8'h3F);
        reg_write(csocr_pkg::OFF_PORT_B, 8'h00);
        settle(3);
        check("lanes", 24'({port_a_lane_enable, port_b_lane_enable}), 24'h000FC0);
        $display("test lanes done");
        // Pass routing to the two pins and live status
        reg_write(csocr_pkg::OFF_PASS, 8'h02);
        @(posedge core_clk);
        pass_in <= 1'b1;
        settle(5);
        check("pins", 24'({gpio3_oe, gpio3_out, gpio0_oe, gpio0_out}), 24'h000003);
        reg_read(csocr_pkg::OFF_PASS, 8'h03);
        reg_write(csocr_pkg::OFF_PASS, 8'h04);
        settle(3);
        check("pins", 24'({gpio3_oe, gpio3_out, gpio0_oe, gpio0_out}), 24'h00000C);
        reg_write(csocr_pkg::OFF_PASS, 8'h06);
        @(posedge core_clk);
        pass_in <= 1'b0;
        settle(5);
        check("pins", 24'({gpio3_oe, gpio3_out, gpio0_oe, gpio0_out}), 24'h00000A);
        reg_read(csocr_pkg::OFF_PASS, 8'h06);
        $display("test pass done");
        // Every virtual channel code
        for (int v = 0; v < 4; v++) begin
            reg_write(csocr_pkg::OFF_VC, {v[1:0], 6'h00});
            settle(3);
            check("vc", 24'(virtual_channel_field), 24'(v[1:0]));
        end
        $display("test channel done");
        // Reset in mid-run restores defaults
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        reg_read(csocr_pkg::OFF_PASS, csocr_pkg::RST_PASS);
        reg_read(csocr_pkg::OFF_PORT_A, csocr_pkg::RST_PORT_A);
        reg_read(csocr_pkg::OFF_VC, csocr_pkg::RST_VC);
        check("vc reset", 24'(virtual_channel_field), 24'h000000);
        check("gpio oe reset", 24'({gpio3_oe, gpio0_oe}), 24'h000001);
        $display("test second reset done");
        end_of_test();
    end
endmodule : test_csi2_output_config_regs
